// [rtl/sscr_pins_if.sv]
// carrier between the synchroniser and the register block
`default_nettype none
interface sscr_pins_if;
   logic [2:0] raw;
   logic [2:0] synced;
   modport sync_side (input raw, output synced);
   modport core_side (output raw, input synced);
endinterface : sscr_pins_if
`default_nettype wire

// [rtl/sscr_pkg.sv]
// constants shared by the spi switch configuration register block
`default_nettype none
package sscr_pkg;
   // register offsets
   localparam logic [6:0] SSCR_SWITCH_STATE_ADDR = 7'h01;
   localparam logic [6:0] SSCR_ERROR_CHECK_CONFIG_ADDR = 7'h02;
   localparam logic [6:0] SSCR_ERROR_FLAGS_ADDR = 7'h03;
   // values after reset
   localparam logic [3:0] SSCR_SWITCH_STATE_RESET = 4'h0;
   localparam logic [2:0] SSCR_ERROR_CHECK_CONFIG_RESET = 3'h6;
   // field positions in error_check_config
   localparam int SSCR_ADDR_CHECK_BIT = 2;
   localparam int SSCR_COUNT_CHECK_BIT = 1;
   localparam int SSCR_CRC_CHECK_BIT = 0;
   // field positions in the error flag byte
   localparam int SSCR_ADDR_FLAG_BIT = 2;
   localparam int SSCR_COUNT_FLAG_BIT = 1;
   // frame layout, counted in serial clock rising edges
   localparam logic [4:0] SSCR_HEADER_EDGES = 5'h08;
   localparam logic [4:0] SSCR_ADDR_CHECK_EDGE = 5'h09;
   localparam logic [4:0] SSCR_DATA_EDGES = 5'h10;
   localparam logic [4:0] SSCR_PLAIN_FRAME_EDGES = 5'h10;
   localparam logic [4:0] SSCR_CRC_FRAME_EDGES = 5'h18;
   localparam logic [4:0] SSCR_EDGE_COUNT_MAX = 5'h1f;
   // header bit 7 low means write
   localparam int SSCR_READ_BIT = 7;
   // error flag clear command
   localparam logic [7:0] SSCR_CLEAR_HEADER = 8'h6c;
   localparam logic [7:0] SSCR_CLEAR_DATA = 8'ha9;
   // pins passed through the synchroniser
   localparam int SSCR_SYNC_WIDTH = 3;
endpackage : sscr_pkg
`default_nettype wire

// [rtl/sscr_sync.sv]
// two-stage synchroniser for the serial pins
`default_nettype none
module sscr_sync
   import sscr_pkg::*;
#(
   parameter int W = SSCR_SYNC_WIDTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // pins in, synchronised copies out
   sscr_pins_if.sync_side pins
);
   logic [W-1:0] first_reg;
   logic [W-1:0] first_next;
   logic [W-1:0] second_reg;
   logic [W-1:0] second_next;

   always_comb begin
      first_next = pins.raw;
      second_next = first_reg;
   end

   // idle pin levels are high so nothing looks like a frame at reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         first_reg <= '1;
         second_reg <= '1;
      end else begin
         first_reg <= first_next;
         second_reg <= second_next;
      end
   end

   assign pins.synced = second_reg;
endmodule : sscr_sync
`default_nettype wire

// [rtl/sscr_top.sv]
// spi-addressed switch state and error check configuration registers
// Summary of operation
// - switch state at 0x01, resets all open
// - bits 3..0 close switches four..one
// - reserved bits read zero, writes ignored
// - check config at 0x02, resets to 0x06
// - config bit 2 enables address check
// - count check expects 16 edges, plain
// - crc on, no burst: expect 24
// - burst: multiples of 16 or 24
// - config bit 0 enables 24-bit crc frames
// - mismatch flags error; short frame no write
// - bad address flagged at edge nine, no write
// - long frame still writes at 16th edge, or 24th with crc on
`default_nettype none
module sscr_top
   import sscr_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // serial link pins
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdi,
   output logic sdo,
   // mode from neighbouring logic on core_clk
   input wire logic burst_mode,
   // switch drives
   output logic first_switch_close,
   output logic second_switch_close,
   output logic third_switch_close,
   output logic fourth_switch_close,
   // error flags
   output logic addr_error_flag,
   output logic count_error_flag
);
   sscr_pins_if pins ();

   assign pins.raw = {cs_n, sclk, sdi};

   sscr_sync #(.W(SSCR_SYNC_WIDTH)) u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pins(pins)
   );

   logic cs_n_s;
   logic sclk_s;
   logic sdi_s;
   assign {cs_n_s, sclk_s, sdi_s} = pins.synced;

   logic [3:0] sw_reg, sw_next;
   logic [2:0] cfg_reg, cfg_next;
   logic addr_err_reg, addr_err_next;
   logic cnt_err_reg, cnt_err_next;
   logic sclk_d_reg, sclk_d_next;
   logic cs_d_reg, cs_d_next;
   logic [6:0] shift_reg, shift_next;
   logic [7:0] hdr_reg, hdr_next;
   logic [7:0] data_reg, data_next;
   logic [7:0] tx_reg, tx_next;
   logic sdo_reg, sdo_next;
   logic [4:0] pos_reg, pos_next;
   logic [4:0] total_reg, total_next;
   logic done_reg, done_next;
   logic bad_reg, bad_next;
   logic crc_l_reg, crc_l_next;
   logic burst_l_reg, burst_l_next;

   logic sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame;
   logic [4:0] edge_num, word_len;
   logic [7:0] new_byte, wdata;
   logic word_end, word_ok, wr_sw_hit, wr_cfg_hit, clear_hit, addr_invalid;

   assign sclk_rise = sclk_s & ~sclk_d_reg;
   assign sclk_fall = ~sclk_s & sclk_d_reg;
   assign cs_fall = ~cs_n_s & cs_d_reg;
   assign cs_rise = cs_n_s & ~cs_d_reg;
   assign in_frame = ~cs_n_s & ~cs_d_reg;
   assign edge_num = pos_reg + 5'h01;
   // crc byte only sets the frame length; its value is never checked here
   assign word_len = crc_l_reg ? SSCR_CRC_FRAME_EDGES : SSCR_PLAIN_FRAME_EDGES;
   assign new_byte = {shift_reg, sdi_s};
   // with crc off the data byte completes on the word's last edge
   assign wdata = crc_l_reg ? data_reg : new_byte;
   assign word_end = in_frame && sclk_rise && (edge_num == word_len);
   // only the first word of a plain frame writes; extra edges are ignored
   assign word_ok = !bad_reg && (burst_l_reg || !done_reg) && !hdr_reg[SSCR_READ_BIT];
   assign clear_hit = word_end && (burst_l_reg || !done_reg) && (hdr_reg == SSCR_CLEAR_HEADER)
      && (wdata == SSCR_CLEAR_DATA);
   assign wr_sw_hit = word_end && word_ok && (hdr_reg[6:0] == SSCR_SWITCH_STATE_ADDR);
   assign wr_cfg_hit = word_end && word_ok && (hdr_reg[6:0] == SSCR_ERROR_CHECK_CONFIG_ADDR);

   // flag register is read only; the clear command is exempt
   always_comb begin
      addr_invalid = 1'b1;
      if (hdr_reg == SSCR_CLEAR_HEADER) begin
         addr_invalid = 1'b0;
      end else if ((hdr_reg[6:0] == SSCR_SWITCH_STATE_ADDR)
         || (hdr_reg[6:0] == SSCR_ERROR_CHECK_CONFIG_ADDR)) begin
         addr_invalid = 1'b0;
      end else if (hdr_reg[6:0] == SSCR_ERROR_FLAGS_ADDR) begin
         addr_invalid = !hdr_reg[SSCR_READ_BIT];
      end
   end

   always_comb begin
      sw_next = sw_reg;
      cfg_next = cfg_reg;
      addr_err_next = addr_err_reg;
      cnt_err_next = cnt_err_reg;
      sclk_d_next = sclk_s;
      cs_d_next = cs_n_s;
      shift_next = shift_reg;
      hdr_next = hdr_reg;
      data_next = data_reg;
      tx_next = tx_reg;
      sdo_next = sdo_reg;
      pos_next = pos_reg;
      total_next = total_reg;
      done_next = done_reg;
      bad_next = bad_reg;
      crc_l_next = crc_l_reg;
      burst_l_next = burst_l_reg;
      if (cs_fall) begin
         // frame length fixed at frame start so a mid-frame write cannot skew it
         pos_next = '0;
         total_next = '0;
         done_next = 1'b0;
         bad_next = 1'b0;
         tx_next = '0;
         crc_l_next = cfg_reg[SSCR_CRC_CHECK_BIT];
         burst_l_next = burst_mode;
      end else if (in_frame && sclk_rise) begin
         shift_next = new_byte[6:0];
         // saturates so an overlong frame cannot wrap back to a legal count
         total_next = (total_reg == SSCR_EDGE_COUNT_MAX) ? total_reg : total_reg + 5'h01;
         pos_next = (edge_num == word_len) ? 5'h00 : edge_num;
         if (edge_num == SSCR_HEADER_EDGES) begin
            hdr_next = new_byte;
            tx_next = '0;
            if (new_byte[6:0] == SSCR_SWITCH_STATE_ADDR) begin
               tx_next[3:0] = sw_reg;
            end else if (new_byte[6:0] == SSCR_ERROR_CHECK_CONFIG_ADDR) begin
               tx_next[2:0] = cfg_reg;
            end else if (new_byte[6:0] == SSCR_ERROR_FLAGS_ADDR) begin
               tx_next[SSCR_ADDR_FLAG_BIT] = addr_err_reg;
               tx_next[SSCR_COUNT_FLAG_BIT] = cnt_err_reg;
            end
         end
         if (edge_num == SSCR_DATA_EDGES) begin
            data_next = new_byte;
         end
         if (word_end) begin
            done_next = 1'b1;
            bad_next = 1'b0;
            if (wr_sw_hit) begin
               sw_next = wdata[3:0];
            end
            if (wr_cfg_hit) begin
               cfg_next = wdata[2:0];
            end
            if (clear_hit) begin
               addr_err_next = 1'b0;
               cnt_err_next = 1'b0;
            end
         end
         if ((edge_num == SSCR_ADDR_CHECK_EDGE) && (burst_l_reg || !done_reg)) begin
            // a disabled check neither flags nor blocks
            if (cfg_reg[SSCR_ADDR_CHECK_BIT] && addr_invalid) begin
               bad_next = 1'b1;
               addr_err_next = 1'b1;
            end
         end
      end else if (in_frame && sclk_fall) begin
         sdo_next = tx_reg[7];
         tx_next = {tx_reg[6:0], 1'b0};
      end
      if (cs_rise) begin
         sdo_next = 1'b0;
         if (cfg_reg[SSCR_COUNT_CHECK_BIT]) begin
            if (burst_l_reg) begin
               if (pos_reg != 5'h00) begin
                  cnt_err_next = 1'b1;
               end
            end else if (total_reg != word_len) begin
               cnt_err_next = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_reg <= SSCR_SWITCH_STATE_RESET;
         cfg_reg <= SSCR_ERROR_CHECK_CONFIG_RESET;
         addr_err_reg <= 1'b0;
         cnt_err_reg <= 1'b0;
         sclk_d_reg <= 1'b1;
         cs_d_reg <= 1'b1;
         shift_reg <= '0;
         hdr_reg <= '0;
         data_reg <= '0;
         tx_reg <= '0;
         sdo_reg <= 1'b0;
         pos_reg <= '0;
         total_reg <= '0;
         done_reg <= 1'b0;
         bad_reg <= 1'b0;
         crc_l_reg <= 1'b0;
         burst_l_reg <= 1'b0;
      end else begin
         sw_reg <= sw_next;
         cfg_reg <= cfg_next;
         addr_err_reg <= addr_err_next;
         cnt_err_reg <= cnt_err_next;
         sclk_d_reg <= sclk_d_next;
         cs_d_reg <= cs_d_next;
         shift_reg <= shift_next;
         hdr_reg <= hdr_next;
         data_reg <= data_next;
         tx_reg <= tx_next;
         sdo_reg <= sdo_next;
         pos_reg <= pos_next;
         total_reg <= total_next;
         done_reg <= done_next;
         bad_reg <= bad_next;
         crc_l_reg <= crc_l_next;
         burst_l_reg <= burst_l_next;
      end
   end

   assign sdo = sdo_reg;
   assign first_switch_close = sw_reg[0];
   assign second_switch_close = sw_reg[1];
   assign third_switch_close = sw_reg[2];
   assign fourth_switch_close = sw_reg[3];
   assign addr_error_flag = addr_err_reg;
   assign count_error_flag = cnt_err_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // qualifiers shared by the checks below
   logic hdr_edge;
   logic chk_edge;
   logic count_on;
   assign hdr_edge = in_frame && sclk_rise && (edge_num == SSCR_HEADER_EDGES);
   assign chk_edge = in_frame && sclk_rise && (edge_num == SSCR_ADDR_CHECK_EDGE);
   assign count_on = cfg_reg[SSCR_COUNT_CHECK_BIT];

   // register contents
   a_sw_write_data: assert property (wr_sw_hit |=> sw_reg == $past(wdata[3:0]))
      else $error("switch state not taken from frame data");
   a_sw_hold: assert property (!wr_sw_hit |=> $stable(sw_reg))
      else $error("switch state changed without a valid write");
   a_cfg_write_data: assert property (wr_cfg_hit |=> cfg_reg == $past(wdata[2:0]))
      else $error("check config not taken from frame data");
   a_cfg_hold: assert property (!wr_cfg_hit |=> $stable(cfg_reg))
      else $error("check config changed without a valid write");
   a_read_reserved_zero: assert property (hdr_edge |=> tx_reg[7:4] == 4'h0)
      else $error("reserved read bits not zero");

   // clock-count check
   a_plain_count_err: assert property (cs_rise && count_on && !burst_l_reg
      && total_reg != word_len |=> cnt_err_reg)
      else $error("plain frame length error not flagged");
   a_burst_count_err: assert property (cs_rise && count_on && burst_l_reg
      && pos_reg != 5'h00 |=> cnt_err_reg)
      else $error("burst frame length error not flagged");
   a_count_check_off: assert property (cs_rise && !count_on && !cnt_err_reg
      |=> !cnt_err_reg)
      else $error("disabled count check raised its flag");
   a_short_no_write: assert property (in_frame && sclk_rise && edge_num != word_len
      |=> $stable(sw_reg) && $stable(cfg_reg))
      else $error("register written before its word was complete");
   a_write_on_edge: assert property (wr_sw_hit && !burst_l_reg
      |-> total_reg + 5'h01 == word_len)
      else $error("plain frame write not on its last word edge");

   // address check
   a_addr_err_set: assert property (chk_edge && !done_reg && addr_invalid
      && cfg_reg[SSCR_ADDR_CHECK_BIT] |=> addr_err_reg && bad_reg)
      else $error("invalid address not flagged at ninth edge");
   a_addr_check_off: assert property (chk_edge && !cfg_reg[SSCR_ADDR_CHECK_BIT]
      && !addr_err_reg |=> !addr_err_reg && !bad_reg)
      else $error("disabled address check flagged or blocked");
   a_addr_no_write: assert property (bad_reg |-> !wr_sw_hit && !wr_cfg_hit)
      else $error("write went through after invalid address");
   a_flag_sticky: assert property (addr_err_reg && !clear_hit |=> addr_err_reg)
      else $error("address error flag dropped without a clear");

   // crc framing
   a_crc_len: assert property (cs_fall ##1 crc_l_reg |-> word_len == SSCR_CRC_FRAME_EDGES)
      else $error("crc frame length not 24");

   c_sw_write: cover property (wr_sw_hit);
   c_crc_write: cover property (wr_cfg_hit && crc_l_reg);
   c_burst_two_words: cover property (word_end && burst_l_reg && done_reg);
   c_addr_error: cover property ($rose(addr_err_reg));
   c_count_error: cover property ($rose(cnt_err_reg));
endmodule : sscr_top
`default_nettype wire

// [tb/sscr_host_model.sv]
// serial host model that sends frames into the register block
`default_nettype none
module sscr_host_model (
   // clock
   input wire logic core_clk,
   // serial link
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // mode 0, msb first; sclk stands low between frames
   // sdo is taken late in the high phase, well after it settles
   task automatic xfer(input logic [47:0] bits, input int n, output logic [47:0] rx);
      rx = '0;
      @(posedge core_clk);
      cs_n <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi <= bits[i];
         repeat (4) @(posedge core_clk);
         sclk <= 1'b1;
         repeat (4) @(posedge core_clk);
         rx = {rx[46:0], sdo};
         sclk <= 1'b0;
      end
      repeat (4) @(posedge core_clk);
      cs_n <= 1'b1;
      // data line no longer meaningful: show the inverse, not a stale bit
      sdi <= ~sdi;
      repeat (8) @(posedge core_clk);
   endtask : xfer
endmodule : sscr_host_model
`default_nettype wire

// [tb/tb_spi_switch_config_registers.sv]
// self-checking bench for the switch state and check configuration registers
`default_nettype none
module tb_spi_switch_config_registers;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [15:0] word;
      logic rd;
      logic [7:0] rdata;
      logic [3:0] sw;
   } sscr_row_type;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic burst_mode = 1'b0;
   logic cs_n, sclk, sdi, sdo;
   logic s1, s2, s3, s4, addr_flag, count_flag;
   logic [47:0] rx;
   int errors = 0;
   int n_compared = 0;
   // reserved data bits always sent as zero
   sscr_row_type rows [7] = '{
      '{16'h0105, 1'b0, 8'h00, 4'h5}, '{16'h8100, 1'b1, 8'h05, 4'h5},
      '{16'h010a, 1'b0, 8'h00, 4'ha}, '{16'h8200, 1'b1, 8'h06, 4'ha},
      '{16'h010f, 1'b0, 8'h00, 4'hf}, '{16'h8300, 1'b1, 8'h00, 4'hf},
      '{16'h0100, 1'b0, 8'h00, 4'h0}};

   always #12.5 core_clk = ~core_clk;

   sscr_top sscr_top_i (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo), .burst_mode(burst_mode), .first_switch_close(s1),
      .second_switch_close(s2), .third_switch_close(s3), .fourth_switch_close(s4),
      .addr_error_flag(addr_flag), .count_error_flag(count_flag));
   sscr_host_model sscr_host_model_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk),
      .sdi(sdi), .sdo(sdo));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : tally_and_finish

   // flags in bits 5..4, switches four..one in bits 3..0
   function automatic logic [7:0] st();
      return {2'b00, addr_flag, count_flag, s4, s3, s2, s1};
   endfunction : st

   task automatic frm(input logic [47:0] bits, input int n, input logic [7:0] exp);
      sscr_host_model_i.xfer(bits, n, rx);
      chk(st(), exp);
   endtask : frm

   initial begin
      repeat (100000) @(posedge core_clk);
      errors++;
      tally_and_finish();
   end

   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk(st(), 8'h00);
      foreach (rows[i]) begin
         frm({32'h0, rows[i].word}, 16, {4'h0, rows[i].sw});
         if (rows[i].rd) begin
            chk(rx[7:0], rows[i].rdata);
         end
         $display("row %0d done", i);
      end
      frm(48'h030f, 16, 8'h20);
      // flag readback: address error sits in bit 2
      frm(48'h8300, 16, 8'h20);
      chk(rx[7:0], 8'h04);
      frm(48'h6ca9, 16, 8'h00);
      frm(48'h040f, 16, 8'h20);
      frm(48'h6ca9, 16, 8'h00);
      $display("test address check done");
      frm(48'h01f, 12, 8'h10);
      frm(48'h6ca9, 16, 8'h00);
      frm(48'h01030, 20, 8'h13);
      // flag readback: clock-count error sits in bit 1
      frm(48'h8300, 16, 8'h13);
      chk(rx[7:0], 8'h02);
      frm(48'h6ca9, 16, 8'h03);
      $display("test count check done");
      frm(48'h0200, 16, 8'h03);
      frm(48'h040f, 16, 8'h03);
      frm(48'h01f, 12, 8'h03);
      $display("test disabled checks done");
      frm(48'h0207, 16, 8'h03);
      frm(48'h010600, 24, 8'h06);
      // deliberately short frame while crc framing is on
      frm(48'h0109, 16, 8'h16);
      frm(48'h6ca900, 24, 8'h06);
      $display("test crc framing done");
      @(posedge core_clk);
      burst_mode <= 1'b1;
      frm(48'h010900010c00, 48, 8'h0c);
      frm(48'h020600, 24, 8'h0c);
      frm(48'h01010102, 32, 8'h02);
      frm(48'h0101010201, 40, 8'h12);
      @(posedge core_clk);
      burst_mode <= 1'b0;
      $display("test burst done");
      rst_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      chk(st(), 8'h00);
      rst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      frm(48'h8200, 16, 8'h00);
      chk(rx[7:0], 8'h06);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : tb_spi_switch_config_registers
`default_nettype wire
